// File: rtp_parity_repair_codec.sv
`include "rtp_fec_defs.svh"

module rtp_parity_repair_codec #(
   parameter int DEPTH = 384
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire rtp_fec_pkg::wb_adr_t wb_adr_i,
   input wire rtp_fec_pkg::wb_word_t wb_dat_i,
   output rtp_fec_pkg::wb_word_t wb_dat_o,
   output logic wb_ack_o
);
   import rtp_fec_pkg::*;

   localparam int AW = $clog2(DEPTH);
   localparam int CLR_LIM = DEPTH + 2;
   localparam logic [AW:0] PTR_END = (AW + 1)'(DEPTH);

   // Clear sweep must fit the bus timeout window and the pointer width
   if (DEPTH < 2 || DEPTH > 512) begin : g_depth_chk
      $error("DEPTH must lie between 2 and 512 words");
   end

   acc_mem_if #(.W(32), .AW(AW)) mem_if ();

   parity_acc_mem #(.W(32), .DEPTH(DEPTH)) u_mem (
      .clk(clk),
      .port(mem_if.mem)
   );

   codec_state_e state_r, state_nxt;
   logic ack_r, ack_nxt;
   wb_word_t dat_r, dat_nxt;
   logic f_r, f_nxt;
   logic rflag_r, rflag_nxt;
   logic [15:0] cur_hdr_r, cur_hdr_nxt;
   logic [15:0] cur_seq_r, cur_seq_nxt;
   logic [31:0] cur_ts_r, cur_ts_nxt;
   logic [15:0] hdr_acc_r, hdr_acc_nxt;
   logic [15:0] len_acc_r, len_acc_nxt;
   logic [31:0] ts_acc_r, ts_acc_nxt;
   logic [15:0] min_seq_r, min_seq_nxt;
   logic [7:0] cnt_r, cnt_nxt;
   logic [15:0] max_len_r, max_len_nxt;
   logic [AW:0] wptr_r, wptr_nxt;
   logic [AW:0] rptr_r, rptr_nxt;
   logic [AW:0] clr_r, clr_nxt;
   wb_word_t hold_r, hold_nxt;
   logic ovf_r, ovf_nxt;
   wb_word_t cfg_r, cfg_nxt;
   logic [3:0][31:0] mask_r, mask_nxt;
   logic [15:0] oob_r, oob_nxt;
   wb_word_t query_r, query_nxt;

   logic req;
   wb_word_t wd;
   wb_word_t rd_word;
   wb_word_t q_result;
   logic [1:0] midx;
   logic [15:0] plen;

   // Merge byte lanes; unselected lanes keep the old value
   function automatic wb_word_t wmerge(wb_word_t old, wb_word_t nw, logic [3:0] sel);
      wb_word_t res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return res;
   endfunction

   // Holding ack out of req keeps one request from being served twice
   assign req = wb_cyc_i && wb_stb_i && !ack_r;
   assign wd = wmerge(32'h0000_0000, wb_dat_i, wb_sel_i);
   assign midx = 2'((wb_adr_i - `A_MASK0) >> 2);
   assign plen = (max_len_r > `RTP_FIXED_LEN) ? 16'(max_len_r - `RTP_FIXED_LEN) : 16'h0000;
   assign wb_dat_o = dat_r;
   assign wb_ack_o = ack_r;

   // ------------------------------------------------------------
   // Association of a repair packet with source sequence numbers
   // ------------------------------------------------------------
   logic [127:0] mask_v;
   logic [15:0] off;
   logic [6:0] mw;
   logic [6:0] midx_bit;
   logic [7:0] e_l, e_d;
   logic [7:0] div_l;
   logic ld_oob, mode_mask, mode_ok, prot;
   logic [8:0] set_size;

   assign mask_v = {mask_r[0], mask_r[1], mask_r[2], mask_r[3]};

   // Combinational lookup; one query register feeds both row and column sets
   always_comb begin
      off = 16'(query_r[`Q_SEQ] - query_r[`Q_BASE]);
      case (cfg_r[`CFG_MSEL])
         `MSEL_15: mw = `MASK_W15;
         `MSEL_46: mw = `MASK_W46;
         default: mw = `MASK_W110;
      endcase
      midx_bit = 7'(16'(mw) - 16'h0001 - off);
      // Header L/D of zero falls back to session-negotiated offsets
      ld_oob = (cfg_r[`CFG_L] == 8'h00) && (cfg_r[`CFG_D] == 8'h00);
      e_l = ld_oob ? oob_r[7:0] : cfg_r[`CFG_L];
      e_d = ld_oob ? oob_r[15:8] : cfg_r[`CFG_D];
      div_l = (e_l == 8'h00) ? 8'h01 : e_l;
      mode_mask = !cfg_r[`CFG_RX_R] && !cfg_r[`CFG_RX_F];
      mode_ok = 1'b0;
      prot = 1'b0;
      set_size = 9'h000;
      if (cfg_r[`CFG_RX_R]) begin
         mode_ok = 1'b0;
      end else if (mode_mask) begin
         mode_ok = 1'b1;
         prot = (off < 16'(mw)) && mask_v[midx_bit];
      end else if (e_l != 8'h00) begin
         mode_ok = 1'b1;
         if (e_d == 8'h00) begin
            prot = off <= 16'(e_l);
            set_size = 9'(e_l) + 9'h001;
         end else begin
            prot = ((off % 16'(div_l)) == 16'h0000) && ((off / 16'(div_l)) <= 16'(e_d));
            set_size = 9'(e_d) + 9'h001;
         end
      end
      // Software picks and rebuilds; one-loss-per-set limit is its own
      q_result = 32'h0000_0000;
      q_result[`QR_PROT] = prot;
      q_result[`QR_VALID] = mode_ok;
      // Retransmission packets claim no session offsets either
      q_result[`QR_OOB] = ld_oob && mode_ok && !mode_mask;
      q_result[`QR_SET] = set_size;
   end

   // Read data selection for plain registers
   always_comb begin
      rd_word = 32'h0000_0000;
      case (wb_adr_i)
         `A_CTRL: begin
            rd_word[`CTRL_F] = f_r;
            rd_word[`CTRL_R] = rflag_r;
         end
         `A_STATUS: begin
            rd_word[`ST_BUSY] = state_r != ST_IDLE;
            rd_word[`ST_OVF] = ovf_r;
            rd_word[`ST_CNT] = cnt_r;
            rd_word[`ST_PLEN] = plen;
         end
         `A_FEC_HDR: begin
            rd_word[`FEC_R_BIT] = rflag_r;
            rd_word[`FEC_F_BIT] = f_r;
            rd_word[`FEC_REC] = hdr_acc_r[`HDR_REC];
            rd_word[`FEC_LEN] = len_acc_r;
         end
         `A_FEC_TS: rd_word = ts_acc_r;
         `A_SN_BASE: rd_word[15:0] = min_seq_r;
         `A_ASSOC_CFG: rd_word = cfg_r;
         `A_OOB_LD: rd_word[15:0] = oob_r;
         `A_QUERY: rd_word = q_result;
         default: begin
            if (wb_adr_i >= `A_MASK0 && wb_adr_i <= `A_MASK3) begin
               rd_word = mask_r[midx];
            end
         end
      endcase
   end

   // Bus sequencing, source folding and accumulator memory control
   always_comb begin
      state_nxt = state_r;
      ack_nxt = 1'b0;
      dat_nxt = dat_r;
      f_nxt = f_r;
      rflag_nxt = rflag_r;
      cur_hdr_nxt = cur_hdr_r;
      cur_seq_nxt = cur_seq_r;
      cur_ts_nxt = cur_ts_r;
      hdr_acc_nxt = hdr_acc_r;
      len_acc_nxt = len_acc_r;
      ts_acc_nxt = ts_acc_r;
      min_seq_nxt = min_seq_r;
      cnt_nxt = cnt_r;
      max_len_nxt = max_len_r;
      wptr_nxt = wptr_r;
      rptr_nxt = rptr_r;
      clr_nxt = clr_r;
      hold_nxt = hold_r;
      ovf_nxt = ovf_r;
      cfg_nxt = cfg_r;
      mask_nxt = mask_r;
      oob_nxt = oob_r;
      query_nxt = query_r;
      mem_if.we = 1'b0;
      mem_if.re = 1'b0;
      mem_if.waddr = wptr_r[AW-1:0];
      mem_if.raddr = rptr_r[AW-1:0];
      mem_if.wdata = 32'h0000_0000;
      case (state_r)
         ST_IDLE: begin
            if (req && wb_we_i) begin
               ack_nxt = 1'b1;
               case (wb_adr_i)
                  `A_CTRL: begin
                     f_nxt = wd[`CTRL_F];
                     rflag_nxt = wd[`CTRL_R];
                     if (wd[`CTRL_START]) begin
                        // New block: wipe all accumulators before any source
                        hdr_acc_nxt = 16'h0000;
                        len_acc_nxt = 16'h0000;
                        ts_acc_nxt = 32'h0000_0000;
                        cnt_nxt = 8'h00;
                        max_len_nxt = 16'h0000;
                        ovf_nxt = 1'b0;
                        wptr_nxt = '0;
                        rptr_nxt = '0;
                        clr_nxt = '0;
                        ack_nxt = 1'b0;
                        state_nxt = ST_CLEAR;
                     end
                  end
                  `A_SRC_HDR: begin
                     cur_hdr_nxt = wd[`SRC_TOP16];
                     cur_seq_nxt = wd[`SRC_SEQ];
                  end
                  `A_SRC_TS: cur_ts_nxt = wd;
                  `A_SRC_LEN: begin
                     // Retransmission-format blocks never fold parity
                     if (!rflag_r) begin
                        hdr_acc_nxt = hdr_acc_r ^ cur_hdr_r;
                        len_acc_nxt = len_acc_r ^ 16'(wd[15:0] - `RTP_FIXED_LEN);
                        ts_acc_nxt = ts_acc_r ^ cur_ts_r;
                        // Wrap-aware compare keeps the base right across 0xFFFF
                        if (cnt_r == 8'h00 || $signed(16'(cur_seq_r - min_seq_r)) < 0) begin
                           min_seq_nxt = cur_seq_r;
                        end
                        if (wd[15:0] > max_len_r) begin
                           max_len_nxt = wd[15:0];
                        end
                        cnt_nxt = 8'(cnt_r + 8'h01);
                        wptr_nxt = '0;
                     end
                  end
                  `A_SRC_DATA: begin
                     if (!rflag_r && wptr_r < PTR_END) begin
                        mem_if.re = 1'b1;
                        mem_if.raddr = wptr_r[AW-1:0];
                        hold_nxt = wd;
                        ack_nxt = 1'b0;
                        state_nxt = ST_RMW;
                     end else if (!rflag_r) begin
                        ovf_nxt = 1'b1; // Longer than the buffer: word dropped
                     end
                  end
                  `A_ASSOC_CFG: cfg_nxt = wmerge(cfg_r, wb_dat_i, wb_sel_i);
                  `A_OOB_LD: oob_nxt = 16'(wmerge({16'h0000, oob_r}, wb_dat_i, wb_sel_i));
                  `A_QUERY: query_nxt = wmerge(query_r, wb_dat_i, wb_sel_i);
                  default: begin
                     if (wb_adr_i >= `A_MASK0 && wb_adr_i <= `A_MASK3) begin
                        mask_nxt[midx] = wmerge(mask_r[midx], wb_dat_i, wb_sel_i);
                     end
                  end
               endcase
            end else if (req) begin
               ack_nxt = 1'b1;
               dat_nxt = rd_word;
               if (wb_adr_i == `A_REPAIR) begin
                  dat_nxt = 32'h0000_0000;
                  if (rptr_r < PTR_END) begin
                     mem_if.re = 1'b1;
                     ack_nxt = 1'b0;
                     state_nxt = ST_REPAIR;
                  end
               end
            end
         end
         ST_CLEAR: begin
            // Zeroed words stand in for the padding of shorter packets
            mem_if.we = 1'b1;
            mem_if.waddr = clr_r[AW-1:0];
            clr_nxt = (AW + 1)'(clr_r + 1'b1);
            if (clr_nxt == PTR_END) begin
               ack_nxt = 1'b1;
               state_nxt = ST_IDLE;
            end
         end
         ST_RMW: begin
            mem_if.we = 1'b1;
            mem_if.wdata = mem_if.rdata ^ hold_r;
            wptr_nxt = (AW + 1)'(wptr_r + 1'b1);
            ack_nxt = 1'b1;
            state_nxt = ST_IDLE;
         end
         ST_REPAIR: begin
            dat_nxt = mem_if.rdata;
            rptr_nxt = (AW + 1)'(rptr_r + 1'b1);
            ack_nxt = 1'b1;
            state_nxt = ST_IDLE;
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   // State registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_r <= ST_IDLE;
         ack_r <= 1'b0;
         dat_r <= 32'h0000_0000;
         f_r <= 1'b0;
         rflag_r <= 1'b0;
         cur_hdr_r <= 16'h0000;
         cur_seq_r <= 16'h0000;
         cur_ts_r <= 32'h0000_0000;
         hdr_acc_r <= 16'h0000;
         len_acc_r <= 16'h0000;
         ts_acc_r <= 32'h0000_0000;
         min_seq_r <= 16'h0000;
         cnt_r <= 8'h00;
         max_len_r <= 16'h0000;
         wptr_r <= '0;
         rptr_r <= '0;
         clr_r <= '0;
         hold_r <= 32'h0000_0000;
         ovf_r <= 1'b0;
         cfg_r <= 32'h0000_0000;
         mask_r <= '0;
         oob_r <= 16'h0000;
         query_r <= 32'h0000_0000;
      end else begin
         state_r <= state_nxt;
         ack_r <= ack_nxt;
         dat_r <= dat_nxt;
         f_r <= f_nxt;
         rflag_r <= rflag_nxt;
         cur_hdr_r <= cur_hdr_nxt;
         cur_seq_r <= cur_seq_nxt;
         cur_ts_r <= cur_ts_nxt;
         hdr_acc_r <= hdr_acc_nxt;
         len_acc_r <= len_acc_nxt;
         ts_acc_r <= ts_acc_nxt;
         min_seq_r <= min_seq_nxt;
         cnt_r <= cnt_nxt;
         max_len_r <= max_len_nxt;
         wptr_r <= wptr_nxt;
         rptr_r <= rptr_nxt;
         clr_r <= clr_nxt;
         hold_r <= hold_nxt;
         ovf_r <= ovf_nxt;
         cfg_r <= cfg_nxt;
         mask_r <= mask_nxt;
         oob_r <= oob_nxt;
         query_r <= query_nxt;
      end
   end

   // Checks on the folding, bus timing and association
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   sequence s_len_write;
      state_r == ST_IDLE && req && wb_we_i && wb_adr_i == `A_SRC_LEN && !rflag_r
         && wb_sel_i == 4'hF;
   endsequence

   sequence s_data_req;
      state_r == ST_IDLE && req && wb_we_i && wb_adr_i == `A_SRC_DATA && !rflag_r
         && wptr_r < PTR_END;
   endsequence

   sequence s_start;
      state_r == ST_IDLE && req && wb_we_i && wb_adr_i == `A_CTRL && wb_sel_i[0]
         && wb_dat_i[`CTRL_START];
   endsequence

   a_len_fold: assert property (s_len_write |=> len_acc_r == ($past(len_acc_r) ^ 16'($past(wb_dat_i[15:0]) - `RTP_FIXED_LEN))) else $error("length field not folded");
   a_hdr_fold: assert property (s_len_write |=> hdr_acc_r == ($past(hdr_acc_r) ^ $past(cur_hdr_r)) && ts_acc_r == ($past(ts_acc_r) ^ $past(cur_ts_r))) else $error("header or timestamp not folded");
   a_base_lowest: assert property (s_len_write |=> min_seq_r == $past(cur_seq_r) || min_seq_r == $past(min_seq_r)) else $error("base not from folded sources");
   a_data_rmw: assert property (s_data_req |=> (state_r == ST_RMW && mem_if.we) ##1 wb_ack_o) else $error("payload word not accumulated in two cycles");
   a_clear_ends: assert property (s_start |-> ##[1:CLR_LIM] wb_ack_o) else $error("clear sweep did not finish");
   a_fec_word: assert property (wb_ack_o && !wb_we_i && wb_adr_i == `A_FEC_HDR |-> wb_dat_o[31:30] == {rflag_r, f_r} && wb_dat_o[15:0] == len_acc_r) else $error("repair header word wrong");
   a_retx_skip: assert property (wb_adr_i == `A_SRC_LEN && rflag_r |=> $stable(len_acc_r) && $stable(cnt_r)) else $error("retransmission block folded");
   a_retx_noassoc: assert property (cfg_r[`CFG_RX_R] |-> !prot && !mode_ok) else $error("retransmission packet associated");
   a_mask_lsb: assert property (mode_mask && off == 16'(mw) - 16'h0001 |-> prot == mask_v[0]) else $error("mask LSB mapping wrong");
   a_row_span: assert property (!mode_mask && !cfg_r[`CFG_RX_R] && e_l != 8'h00 && e_d == 8'h00 |-> prot == (off <= 16'(e_l))) else $error("row span wrong");
   a_oob_used: assert property (ld_oob |-> e_l == oob_r[7:0] && e_d == oob_r[15:8]) else $error("session offsets not used");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held over two cycles");
endmodule

// File: rtp_fec_defs.svh
`ifndef RTP_FEC_DEFS_SVH
`define RTP_FEC_DEFS_SVH

// Register byte addresses on the Wishbone bus
`define A_CTRL 8'h00
`define A_SRC_HDR 8'h04
`define A_SRC_TS 8'h08
`define A_SRC_LEN 8'h0C
`define A_SRC_DATA 8'h10
`define A_STATUS 8'h14
`define A_FEC_HDR 8'h18
`define A_FEC_TS 8'h1C
`define A_SN_BASE 8'h20
`define A_ASSOC_CFG 8'h24
`define A_MASK0 8'h28
`define A_MASK3 8'h34
`define A_OOB_LD 8'h38
`define A_REPAIR 8'h3C
`define A_QUERY 8'h40

// Control register bits
`define CTRL_START 0
`define CTRL_F 1
`define CTRL_R 2

// Association configuration fields
`define CFG_L 7:0
`define CFG_D 15:8
`define CFG_MSEL 17:16
`define CFG_RX_R 18
`define CFG_RX_F 19

// Source packet and query word fields
`define SRC_TOP16 31:16
`define SRC_SEQ 15:0
`define Q_BASE 31:16
`define Q_SEQ 15:0

// Repair header word fields
`define FEC_R_BIT 31
`define FEC_F_BIT 30
`define FEC_REC 29:16
`define FEC_LEN 15:0
`define HDR_REC 13:0

// Status word fields
`define ST_BUSY 0
`define ST_OVF 1
`define ST_CNT 15:8
`define ST_PLEN 31:16

// Query result fields
`define QR_PROT 0
`define QR_VALID 1
`define QR_OOB 2
`define QR_SET 24:16

// Protocol constants
`define RTP_FIXED_LEN 16'h000C
`define MASK_W15 7'h0F
`define MASK_W46 7'h2E
`define MASK_W110 7'h6E
`define MSEL_15 2'h0
`define MSEL_46 2'h1
`define MASK_WORDS 4

`endif

// File: rtp_fec_pkg.sv
package rtp_fec_pkg;
   typedef logic [7:0] wb_adr_t;
   typedef logic [31:0] wb_word_t;
   typedef enum {ST_IDLE, ST_CLEAR, ST_RMW, ST_REPAIR} codec_state_e;
endpackage

// File: acc_mem_if.sv
interface acc_mem_if #(
   parameter int W = 32,
   parameter int AW = 9
);
   logic we;
   logic re;
   logic [AW-1:0] waddr;
   logic [AW-1:0] raddr;
   logic [W-1:0] wdata;
   logic [W-1:0] rdata;
   modport ctrl(output we, re, waddr, raddr, wdata, input rdata);
   modport mem(input we, re, waddr, raddr, wdata, output rdata);
endinterface

// File: parity_acc_mem.sv
module parity_acc_mem #(
   parameter int W = 32,
   parameter int DEPTH = 384
) (
   input wire logic clk,
   acc_mem_if.mem port
);
   logic [W-1:0] ram [DEPTH];
   logic [W-1:0] rdata_r;

   // Plain synchronous RAM, read data held in a register
   always_ff @(posedge clk) begin
      if (port.we) begin
         ram[port.waddr] <= port.wdata;
      end
      if (port.re) begin
         rdata_r <= ram[port.raddr];
      end
   end

   assign port.rdata = rdata_r;
endmodule

// File: rtp_src_model.sv
// Far-side source endpoint: supplies version-2 source packets for one block
module rtp_src_model;
   timeunit 1ns;
   timeprecision 1ps;

   // First header half; top two bits are always version 2
   function automatic logic [15:0] top(input int k);
      return (k != 0) ? 16'hA264 : 16'h80E1;
   endfunction

   // Sequence numbers straddle the 16-bit wrap on purpose
   function automatic logic [15:0] seq(input int k);
      return (k != 0) ? 16'h0001 : 16'hFFFE;
   endfunction

   // Timestamps
   function automatic logic [31:0] ts(input int k);
      return (k != 0) ? 32'h0F0F0001 : 32'h12345678;
   endfunction

   // Unequal lengths so the shorter one must be padded by the codec
   function automatic logic [15:0] len(input int k);
      return (k != 0) ? 16'h0010 : 16'h0014;
   endfunction

   // Octets after the fixed header, four at a time, first octet in the top byte
   function automatic logic [31:0] word(input int k, input int w);
      if (k != 0) begin
         return 32'h55667788;
      end
      return (w != 0) ? 32'h11223344 : 32'hA1B2C3D4;
   endfunction
endmodule

// File: tb_rtp_parity_repair_codec.sv
`include "rtp_fec_defs.svh"

module tb_rtp_parity_repair_codec;
   timeunit 1ns;
   timeprecision 1ps;
   import rtp_fec_pkg::*;

   logic clk, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [3:0] wb_sel_i;
   wb_adr_t wb_adr_i;
   wb_word_t wb_dat_i, wb_dat_o, rd;
   logic [15:0] b, hx, lx;
   int bad_count, checks, m;
   int widths[3] = '{15, 46, 110};

   // Small payload RAM keeps the clear sweep short
   rtp_parity_repair_codec #(.DEPTH(16)) rtp_parity_repair_codec_i (
      .clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

   rtp_src_model peer();

   // Clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic cmp(input string nm, input wb_word_t ex, input wb_word_t got);
      checks++;
      if (got !== ex) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, ex, got);
      end
   endtask

   // Classic single cycle; request held until ack is sampled high
   task automatic wb(input logic w, input wb_adr_t a, input wb_word_t d,
                     input logic [3:0] s = 4'hF);
      int n;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_sel_i <= s;
      wb_adr_i <= a;
      wb_dat_i <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 100);
      if (n >= 100) begin
         bad_count++;
         $display("[FAIL] ack at %h expected 1 seen %b", a, wb_ack_o);
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rdc(input wb_adr_t a, input wb_word_t msk, input wb_word_t ex, input string nm);
      wb(1'b0, a, 32'h0);
      cmp(nm, ex & msk, rd & msk);
   endtask

   // One whole source packet: header, timestamp, length, then payload words
   task automatic send(input int k);
      wb(1'b1, `A_SRC_HDR, {peer.top(k), peer.seq(k)});
      wb(1'b1, `A_SRC_TS, peer.ts(k));
      wb(1'b1, `A_SRC_LEN, {16'h0, peer.len(k)});
      for (int w = 0; w < (peer.len(k) - 12) / 4; w++) begin
         wb(1'b1, `A_SRC_DATA, peer.word(k, w));
      end
   endtask

   // Association query against base b; size 0 means the set size is not checked
   task automatic q(input logic [15:0] s, input logic [2:0] ex, input logic [8:0] sz,
                    input string nm);
      wb(1'b1, `A_QUERY, {b, s});
      wb(1'b0, `A_QUERY, 32'h0);
      cmp(nm, {7'h0, sz, 13'h0, ex}, rd & ((sz == 9'h0) ? 32'h7 : 32'h01FF0007));
   endtask

   // Watchdog sized well beyond the few hundred cycles the tests need
   initial begin
      repeat (30000) @(posedge clk);
      bad_count++;
      report_and_stop();
   end

   initial begin
      rstn = 1'b0;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      // Qualifiers stay unset until the first request; the slave ignores them while cyc is low
      bad_count = 0;
      checks = 0;
      b = 16'hFFFE;
      hx = peer.top(0) ^ peer.top(1);
      lx = (peer.len(0) - 16'h000C) ^ (peer.len(1) - 16'h000C);
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      // Build repair data for F=0, F=1 and the retransmission flag
      for (m = 0; m < 3; m++) begin
         wb(1'b1, `A_CTRL, {29'h0, m[1:0], 1'b1});
         send(0);
         send(1);
         if (m == 2) begin
            rdc(`A_FEC_HDR, 32'hC0000000, 32'h80000000, "fec_hdr_r");
            rdc(`A_REPAIR, 32'hFFFFFFFF, 32'h0, "repair_r");
         end else begin
            rdc(`A_FEC_HDR, 32'hFFFFFFFF, {1'b0, m[0], hx[13:0], lx}, "fec_hdr");
            rdc(`A_FEC_TS, 32'hFFFFFFFF, peer.ts(0) ^ peer.ts(1), "fec_ts");
            rdc(`A_SN_BASE, 32'h0000FFFF, {16'h0, b}, "sn_base");
            rdc(`A_STATUS, 32'hFFFFFF03, 32'h00080200, "status");
            rdc(`A_REPAIR, 32'hFFFFFFFF, peer.word(0, 0) ^ peer.word(1, 0), "repair0");
            rdc(`A_REPAIR, 32'hFFFFFFFF, peer.word(0, 1), "repair1");
         end
         $display("build test %0d done", m);
      end
      // Mask association: first and last bit of each width set, i=1 clear
      for (m = 0; m < 3; m++) begin
         for (int a = 0; a < 4; a++) begin
            wb(1'b1, `A_MASK0 + 8'(4 * a), 32'h0);
         end
         wb(1'b1, `A_MASK3, (m == 0) ? 32'h00004001 : 32'h00000001);
         if (m > 0) begin
            wb(1'b1, (m == 1) ? `A_MASK0 + 8'h08 : `A_MASK0, 32'h00002000);
         end
         wb(1'b1, `A_ASSOC_CFG, {14'h0, m[1:0], 16'h0});
         q(b, 3'b011, 9'h0, "mask_first");
         q(b + 16'(widths[m] - 1), 3'b011, 9'h0, "mask_last");
         q(b + 16'h1, 3'b010, 9'h0, "mask_clear");
      end
      $display("mask test done");
      // Row L=4, column L=3 D=2, session L=2, then retransmission format
      wb(1'b1, `A_ASSOC_CFG, 32'h00080004);
      q(16'h0002, 3'b011, 9'd5, "row_last");
      q(16'h0003, 3'b010, 9'd5, "row_out");
      // Byte-lane writes: L lane then D lane, unselected lanes must be kept
      wb(1'b1, `A_ASSOC_CFG, 32'hFFFFFF03, 4'h1);
      wb(1'b1, `A_ASSOC_CFG, 32'hFFFF02FF, 4'h2);
      rdc(`A_ASSOC_CFG, 32'hFFFFFFFF, 32'h00080203, "cfg_lanes");
      q(16'h0004, 3'b011, 9'd3, "col_last");
      q(16'h0001, 3'b011, 9'd3, "col_mid");
      q(16'h0002, 3'b010, 9'd3, "col_gap");
      wb(1'b1, `A_OOB_LD, 32'h00000002);
      wb(1'b1, `A_ASSOC_CFG, 32'h00080000);
      q(16'h0000, 3'b111, 9'd3, "session_row");
      wb(1'b1, `A_ASSOC_CFG, 32'h00040000);
      q(b, 3'b000, 9'h0, "retrans_q");
      rdc(8'h80, 32'hFFFFFFFF, 32'h0, "unmapped");
      $display("offset test done");
      // Reset in mid-run: registers back to zero, bus usable on the next edge
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      rdc(`A_ASSOC_CFG, 32'hFFFFFFFF, 32'h0, "cfg_reset");
      rdc(`A_STATUS, 32'hFFFFFFFF, 32'h0, "status_reset");
      $display("reset test done");
      report_and_stop();
   end
endmodule
